// File: src/megs_consts.vh
// offsets, field positions and reset values of the two status registers
// assumes inclusion by every design file of the status block
`ifndef MEGS_CONSTS_VH
`define MEGS_CONSTS_VH

`define MEGS_ADDR_EVT_STATUS 8'h23
`define MEGS_ADDR_PIN_STATUS 8'h24
`define MEGS_STATUS_RESET 8'h00
`define MEGS_READ_UNMAPPED 8'h00

`define MEGS_BIT_INT_TEMP 0
`define MEGS_BIT_BATTERY 1
`define MEGS_BIT_AIN_NINE 2
`define MEGS_BIT_THERMAL 3
`define MEGS_BIT_FAN_CTRL 4
`define MEGS_BIT_UNUSED 5
`define MEGS_BIT_CHASSIS 6
`define MEGS_BIT_PIN16 7

`define MEGS_CFG_DIR_BIT(k) (2 * (k))
`define MEGS_CFG_POL_BIT(k) (2 * (k) + 1)
`define MEGS_PINS_PER_CFG 4

`endif

// File: src/megs_event_flag.v
// sticky one-shot event flag fed by a level
// assumes the level is synchronous to ref_clk
`timescale 1ns/100ps
`include "megs_consts.vh"

module megs_event_flag #(
   parameter BOTH_EDGES = 1
) (
   input wire ref_clk,
   input wire nrst,
   input wire level,
   input wire arm,
   input wire clear,
   output reg flag_reg
);
   reg level_reg;
   wire rise;
   wire fall;
   wire hit;

   assign rise = level & ~level_reg;
   assign fall = ~level & level_reg;
   assign hit = arm & (rise | ((BOTH_EDGES != 0) & fall));

   always @(posedge ref_clk) begin
      if (!nrst) begin
         level_reg <= 1'b0;
         flag_reg <= 1'b0;
      end else begin
         level_reg <= level;
         // set wins so an edge in the clearing cycle is kept
         if (hit)
            flag_reg <= 1'b1;
         else if (clear)
            flag_reg <= 1'b0;
      end
   end
endmodule

// File: src/megs_pin_bit.v
// one general-purpose pin with its status bit, polarity and direction
// assumes the pad input is synchronous to ref_clk
`timescale 1ns/100ps
`include "megs_consts.vh"

module megs_pin_bit (
   input wire ref_clk,
   input wire nrst,
   input wire dir_out,
   input wire act_high,
   input wire pin_in,
   input wire wr_en,
   input wire wr_bit,
   output wire status,
   output reg pin_out_reg,
   output reg pin_oe_n_reg
);
   reg drive_reg;
   wire in_asserted;
   wire drive_next;

   assign in_asserted = act_high ? pin_in : ~pin_in;
   // write ignored unless the pin is an output
   assign drive_next = (wr_en && dir_out) ? wr_bit : drive_reg;
   assign status = dir_out ? drive_reg : in_asserted;

   always @(posedge ref_clk) begin
      if (!nrst) begin
         drive_reg <= 1'b0;
         pin_out_reg <= 1'b0;
         pin_oe_n_reg <= 1'b1;
      end else begin
         drive_reg <= drive_next;
         pin_out_reg <= act_high ? drive_next : ~drive_next;
         pin_oe_n_reg <= ~dir_out;
      end
   end
endmodule

// File: src/megs_status_top.v
// event, limit and pin status registers of the hardware monitor
// assumes a register port from the serial management bus slave, per-channel
// conversion results with limits, and thermal/fan mode levels from elsewhere
`timescale 1ns/100ps
`include "megs_consts.vh"

module megs_status_top (
   input wire ref_clk,
   input wire nrst,
   input wire [7:0] reg_addr,
   input wire reg_wr_en,
   input wire [7:0] reg_wr_data,
   input wire reg_rd_en,
   output reg [7:0] reg_rd_data,
   output reg reg_rd_valid,
   input wire int_conv_done,
   input wire [7:0] int_value,
   input wire [7:0] int_high_limit,
   input wire [7:0] int_low_limit,
   input wire battery_voltage_conv_done,
   input wire [7:0] battery_voltage_value,
   input wire [7:0] battery_voltage_high_limit,
   input wire [7:0] battery_voltage_low_limit,
   input wire analog_input_nine_conv_done,
   input wire [7:0] analog_input_nine_value,
   input wire [7:0] analog_input_nine_high_limit,
   input wire [7:0] analog_input_nine_low_limit,
   input wire int_thermal_limit_mode,
   input wire thermal_limit_mode,
   input wire automatic_fan_control_en,
   input wire automatic_fan_control_running,
   input wire chassis_intrusion,
   input wire [7:0] pin_cfg_one,
   input wire [7:0] pin_cfg_two,
   input wire general_pin_sixteen_dir_out,
   input wire general_pin_sixteen_act_high,
   input wire general_pin_sixteen_in,
   output wire general_pin_sixteen_out,
   output wire general_pin_sixteen_oe_n,
   input wire [7:0] pin_in,
   output wire [7:0] pin_out,
   output wire [7:0] pin_oe_n
);
   // state of the read path: a read of the event register also clears events
   localparam ST_IDLE = 2'b01;
   localparam ST_CLEAR = 2'b10;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg int_limit_reg;
   reg battery_limit_reg;
   reg ain_nine_limit_reg;
   reg [7:0] rd_data_next;
   reg [3:0] seen_reg;
   wire [3:0] evt_flags;
   wire [3:0] flag_clear;
   wire evt_wr;
   wire pins_wr;
   wire sel_evt;
   wire sel_pins;
   wire evt_read;
   wire evt_clear;
   wire int_thermal_limit_mode_flag;
   wire thermal_limit_mode_flag;
   wire fan_flag;
   wire chassis_flag;
   wire pin16_status;
   wire [7:0] pin_status;
   wire [7:0] evt_status;
   wire [7:0] pin_dir;
   wire [7:0] pin_pol;

   // true when a result lies above the high limit or below the low limit
   function out_of_window;
      input [7:0] value;
      input [7:0] high;
      input [7:0] low;
      begin
         out_of_window = (value > high) || (value < low);
      end
   endfunction

   // direction and polarity fields of a pin in either configuration byte
   function cfg_field;
      input [7:0] cfg_a;
      input [7:0] cfg_b;
      input integer pin;
      input polarity;
      reg [7:0] cfg;
      integer idx;
      begin
         cfg = (pin < `MEGS_PINS_PER_CFG) ? cfg_a : cfg_b;
         idx = polarity ? `MEGS_CFG_POL_BIT(pin % `MEGS_PINS_PER_CFG)
                        : `MEGS_CFG_DIR_BIT(pin % `MEGS_PINS_PER_CFG);
         cfg_field = cfg[idx];
      end
   endfunction

   assign sel_evt = (reg_addr == `MEGS_ADDR_EVT_STATUS);
   assign sel_pins = (reg_addr == `MEGS_ADDR_PIN_STATUS);
   assign evt_read = reg_rd_en && sel_evt;
   assign evt_wr = reg_wr_en && sel_evt;
   assign pins_wr = reg_wr_en && sel_pins;

   // limit flags: replaced at each conversion end, never accumulated
   always @(posedge ref_clk) begin
      if (!nrst) begin
         int_limit_reg <= 1'b0;
         battery_limit_reg <= 1'b0;
         ain_nine_limit_reg <= 1'b0;
      end else begin
         if (int_conv_done)
            int_limit_reg <= out_of_window(int_value, int_high_limit,
                                           int_low_limit);
         if (battery_voltage_conv_done)
            battery_limit_reg <= out_of_window(battery_voltage_value,
                                               battery_voltage_high_limit,
                                               battery_voltage_low_limit);
         if (analog_input_nine_conv_done)
            ain_nine_limit_reg <= out_of_window(analog_input_nine_value,
                                                analog_input_nine_high_limit,
                                                analog_input_nine_low_limit);
      end
   end

   // events stay until the read of the event register has been answered,
   // so software always sees an event at least once before it goes
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (evt_read)
               state_next = ST_CLEAR;
         end
         ST_CLEAR: begin
            state_next = evt_read ? ST_CLEAR : ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   assign evt_clear = (state_reg == ST_CLEAR);
   assign evt_flags = {chassis_flag, fan_flag, thermal_limit_mode_flag, int_thermal_limit_mode_flag};
   // only flags that the answered read showed are cleared, so an edge that
   // lands on the read edge itself is kept for the next read
   assign flag_clear = evt_clear ? seen_reg : 4'h0;

   always @(posedge ref_clk) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         seen_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (evt_read)
            seen_reg <= evt_flags;
      end
   end

   megs_event_flag #(
      .BOTH_EDGES(1)
   ) u_int_thermal_limit_mode (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .level(int_thermal_limit_mode),
      .arm(1'b1),
      .clear(flag_clear[0]),
      .flag_reg(int_thermal_limit_mode_flag)
   );

   megs_event_flag #(
      .BOTH_EDGES(1)
   ) u_thermal_limit_mode (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .level(thermal_limit_mode),
      .arm(1'b1),
      .clear(flag_clear[1]),
      .flag_reg(thermal_limit_mode_flag)
   );

   // only start and stop made by the automatic mode count
   megs_event_flag #(
      .BOTH_EDGES(1)
   ) u_fan (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .level(automatic_fan_control_running),
      .arm(automatic_fan_control_en),
      .clear(flag_clear[2]),
      .flag_reg(fan_flag)
   );

   // rising edge only: the latch outlives the intrusion level
   megs_event_flag #(
      .BOTH_EDGES(0)
   ) u_chassis (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .level(chassis_intrusion),
      .arm(1'b1),
      .clear(flag_clear[3]),
      .flag_reg(chassis_flag)
   );

   megs_pin_bit u_pin16 (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .dir_out(general_pin_sixteen_dir_out),
      .act_high(general_pin_sixteen_act_high),
      .pin_in(general_pin_sixteen_in),
      .wr_en(evt_wr),
      .wr_bit(reg_wr_data[`MEGS_BIT_PIN16]),
      .status(pin16_status),
      .pin_out_reg(general_pin_sixteen_out),
      .pin_oe_n_reg(general_pin_sixteen_oe_n)
   );

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_pin
         assign pin_dir[g] = cfg_field(pin_cfg_one, pin_cfg_two, g, 1'b0);
         assign pin_pol[g] = cfg_field(pin_cfg_one, pin_cfg_two, g, 1'b1);
         megs_pin_bit u_pin (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .dir_out(pin_dir[g]),
            .act_high(pin_pol[g]),
            .pin_in(pin_in[g]),
            .wr_en(pins_wr),
            .wr_bit(reg_wr_data[g]),
            .status(pin_status[g]),
            .pin_out_reg(pin_out[g]),
            .pin_oe_n_reg(pin_oe_n[g])
         );
      end
   endgenerate

   assign evt_status[`MEGS_BIT_INT_TEMP] = int_limit_reg | int_thermal_limit_mode_flag;
   assign evt_status[`MEGS_BIT_BATTERY] = battery_limit_reg;
   assign evt_status[`MEGS_BIT_AIN_NINE] = ain_nine_limit_reg;
   assign evt_status[`MEGS_BIT_THERMAL] = thermal_limit_mode_flag;
   assign evt_status[`MEGS_BIT_FAN_CTRL] = fan_flag;
   assign evt_status[`MEGS_BIT_UNUSED] = 1'b0;
   assign evt_status[`MEGS_BIT_CHASSIS] = chassis_flag;
   assign evt_status[`MEGS_BIT_PIN16] = pin16_status;

   always @* begin
      rd_data_next = `MEGS_READ_UNMAPPED;
      if (sel_evt)
         rd_data_next = evt_status;
      else if (sel_pins)
         rd_data_next = pin_status;
   end

   always @(posedge ref_clk) begin
      if (!nrst) begin
         reg_rd_data <= `MEGS_STATUS_RESET;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en)
            reg_rd_data <= rd_data_next;
      end
   end
endmodule

// File: sim/megs_status_sva.sv
// assertions on the status block ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
module megs_status_sva (
   input wire ref_clk,
   input wire nrst,
   input wire [7:0] reg_addr,
   input wire reg_wr_en,
   input wire [7:0] reg_wr_data,
   input wire reg_rd_en,
   input wire [7:0] reg_rd_data,
   input wire reg_rd_valid,
   input wire int_conv_done,
   input wire [7:0] int_value,
   input wire [7:0] int_high_limit,
   input wire [7:0] int_low_limit,
   input wire thermal_limit_mode,
   input wire automatic_fan_control_en,
   input wire automatic_fan_control_running,
   input wire chassis_intrusion,
   input wire [7:0] pin_cfg_one,
   input wire [7:0] pin_in,
   input wire [7:0] pin_out,
   input wire [7:0] pin_oe_n
);
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);
   sequence rd_evt;
      reg_rd_en && reg_addr == 8'h23;
   endsequence
   // flags land on the edge that samples the change, yet a read is only judged after three idle ones
   sequence quiet_rd;
      !reg_rd_en [*3] ##1 rd_evt;
   endsequence
   sequence pin0_wr;
      reg_wr_en && reg_addr == 8'h24 && pin_cfg_one[0];
   endsequence
   reset_zero_a: assert property ($rose(nrst) |-> !reg_rd_valid && reg_rd_data == 8'h00)
      else $error("outputs not cleared by reset");
   unused_bit_a: assert property (rd_evt |=> reg_rd_valid && !reg_rd_data[5])
      else $error("unused bit read as one");
   int_limit_a: assert property (int_conv_done && (int_value > int_high_limit ||
      int_value < int_low_limit) ##1 !int_conv_done ##1 rd_evt |=> reg_rd_data[0])
      else $error("limit flag missing");
   thermal_limit_mode_event_a: assert property ($changed(thermal_limit_mode) && !reg_rd_en ##1 quiet_rd
      |=> reg_rd_data[3]) else $error("thermal event flag missing");
   fan_event_a: assert property (automatic_fan_control_en && !reg_rd_en &&
      $changed(automatic_fan_control_running) ##1 quiet_rd |=> reg_rd_data[4])
      else $error("fan event flag missing");
   chassis_latch_a: assert property ($rose(chassis_intrusion) && !reg_rd_en ##1 quiet_rd
      |=> reg_rd_data[6]) else $error("chassis flag missing");
   pin_dir_a: assert property ($past(nrst) && $stable(pin_cfg_one) |-> pin_oe_n[3:0] ==
      ~{pin_cfg_one[6], pin_cfg_one[4], pin_cfg_one[2], pin_cfg_one[0]})
      else $error("pin enable not following direction");
   pin_write_a: assert property (pin0_wr ##1 (!reg_wr_en && $stable(pin_cfg_one)) [*2]
      |-> pin_out[0] == ($past(reg_wr_data[0], 2) ~^ pin_cfg_one[1]))
      else $error("pin drive not following write");
   pin_read_a: assert property ((!pin_cfg_one[0] && $stable(pin_in) &&
      $stable(pin_cfg_one)) [*3] ##0 (reg_rd_en && reg_addr == 8'h24)
      |=> reg_rd_data[0] == ($past(pin_in[0]) ~^ $past(pin_cfg_one[1])))
      else $error("input pin status wrong");
endmodule

bind megs_status_top megs_status_sva megs_status_sva_i (.ref_clk, .nrst, .reg_addr, .reg_wr_en,
   .reg_wr_data, .reg_rd_en, .reg_rd_data, .reg_rd_valid, .int_conv_done, .int_value,
   .int_high_limit, .int_low_limit, .thermal_limit_mode, .automatic_fan_control_en,
   .automatic_fan_control_running, .chassis_intrusion, .pin_cfg_one, .pin_in, .pin_out,
   .pin_oe_n);

// File: sim/megs_host_model.sv
// host side of the register port, standing in for the serial bus slave
// assumes one clock; each access holds its strobe for exactly one taken edge
`timescale 1ns/100ps
module megs_host_model (
   input wire ref_clk,
   output logic [7:0] reg_addr,
   output logic reg_wr_en,
   output logic [7:0] reg_wr_data,
   output logic reg_rd_en,
   input wire [7:0] reg_rd_data,
   input wire reg_rd_valid
);
   initial begin
      reg_addr = 8'h00;
      reg_wr_en = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en = 1'b0;
   end
   // released lines show the inverse so stale values cannot pass
   task wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wr_data <= dat;
      reg_wr_en <= 1'b1;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      reg_addr <= ~a;
      reg_wr_data <= ~dat;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] dat);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      reg_addr <= ~a;
      #1;
      dat = reg_rd_valid === 1'b1 ? reg_rd_data : 8'hxx;
   endtask
endmodule

// File: sim/tb_top.sv
// testbench for the status registers: limits, events, pins
// assumes megs_host_model as the register-port partner
`timescale 1ns/100ps
module tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   wire [7:0] reg_addr, reg_wr_data, reg_rd_data, pout, poe;
   wire reg_wr_en, reg_rd_en, reg_rd_valid, o16, e16;
   logic [7:0] val[3], hi[3], lo[3];
   logic [7:0] c1, c2, pin, d, w, w16, p, m;
   logic [2:0] done = 3'h0;
   logic [3:0] lv = 4'h0;
   logic fen = 1'b1;
   logic d16 = 1'b0;
   logic a16 = 1'b1;
   logic i16 = 1'b0;
   int seed = 32'h4641;
   int n_fail = 0;
   int compares = 0;
   int i;
   int bp[4] = '{0, 3, 4, 6};
   always #10 ref_clk = ~ref_clk;
   megs_host_model host_i (.ref_clk, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
      .reg_rd_data, .reg_rd_valid);
   megs_status_top megs_status_top_i (.ref_clk, .nrst, .reg_addr, .reg_wr_en, .reg_wr_data,
      .reg_rd_en, .reg_rd_data, .reg_rd_valid, .int_conv_done(done[0]), .int_value(val[0]),
      .int_high_limit(hi[0]), .int_low_limit(lo[0]), .battery_voltage_conv_done(done[1]),
      .battery_voltage_value(val[1]), .battery_voltage_high_limit(hi[1]),
      .battery_voltage_low_limit(lo[1]), .analog_input_nine_conv_done(done[2]),
      .analog_input_nine_value(val[2]), .analog_input_nine_high_limit(hi[2]),
      .analog_input_nine_low_limit(lo[2]), .int_thermal_limit_mode(lv[0]),
      .thermal_limit_mode(lv[1]), .automatic_fan_control_en(fen),
      .automatic_fan_control_running(lv[2]), .chassis_intrusion(lv[3]), .pin_cfg_one(c1),
      .pin_cfg_two(c2), .general_pin_sixteen_dir_out(d16), .general_pin_sixteen_act_high(a16),
      .general_pin_sixteen_in(i16), .general_pin_sixteen_out(o16),
      .general_pin_sixteen_oe_n(e16), .pin_in(pin), .pin_out(pout), .pin_oe_n(poe));
   task summarize;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // {polarity, direction} per pin out of the two config bytes
   function logic [15:0] split(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] c;
      c = {b, a};
      for (int k = 0; k < 8; k++)
         {split[k + 8], split[k]} = c[2 * k +: 2];
   endfunction
   // edg puts the value on both limits: strict compare must not flag it
   task conv(input int c, input bit edg);
      logic [7:0] v, h, l;
      v = 8'($random(seed));
      h = edg ? v : 8'($random(seed));
      l = edg ? v : h >> 1;
      @(posedge ref_clk);
      val[c] <= v;
      hi[c] <= h;
      lo[c] <= l;
      done[c] <= 1'b1;
      @(posedge ref_clk);
      done[c] <= 1'b0;
      host_i.rd(8'h23, d);
      chk({7'h00, d[c]}, {7'h00, v > h || v < l});
   endtask
   task ev(input int n, input bit v, input logic [7:0] e);
      @(posedge ref_clk);
      lv[n] <= v;
      repeat (2) @(posedge ref_clk);
      if (n == 3)
         lv[n] <= 1'b0;
      @(posedge ref_clk);
      host_i.rd(8'h23, d);
      chk(d & 8'h79, e);
      host_i.rd(8'h23, d);
      chk(d & 8'h79, 8'h00);
   endtask
   initial begin
      c1 = 8'haa;
      c2 = 8'haa;
      pin = 8'h00;
      for (i = 0; i < 3; i++) begin
         val[i] = 8'h00;
         hi[i] = 8'hff;
         lo[i] = 8'h00;
      end
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      host_i.rd(8'h23, d);
      chk(d, 8'h00);
      host_i.rd(8'h24, d);
      chk(d, 8'h00);
      host_i.rd(8'h30, d);
      chk(d, 8'h00);
      $display("reset test done");
      for (i = 0; i < 13; i++)
         conv(i % 3, i < 3 || i == 12);
      $display("limit test done");
      for (i = 0; i < 4; i++) begin
         ev(i, 1'b1, 8'h01 << bp[i]);
         if (i < 3)
            ev(i, 1'b0, 8'h01 << bp[i]);
      end
      // thermal edge on the very edge that takes a read: shown by the next read only
      fork
         host_i.rd(8'h23, d);
         begin
            @(posedge ref_clk);
            lv[1] <= 1'b1;
         end
      join
      chk(d & 8'h08, 8'h00);
      host_i.rd(8'h23, d);
      chk(d & 8'h08, 8'h08);
      @(posedge ref_clk);
      fen <= 1'b0;
      ev(2, 1'b1, 8'h00);
      $display("event test done");
      for (i = 0; i < 10; i++) begin
         {w, w16, p, m} = $random(seed);
         @(posedge ref_clk);
         c1 <= i == 0 ? 8'h55 : i == 1 ? 8'haa : p;
         c2 <= i == 0 ? 8'h55 : i == 1 ? 8'haa : m;
         pin <= w ^ w16;
         {d16, a16, i16} <= i < 2 ? {i == 0, 2'h1} : w[2:0];
         host_i.wr(8'h23, w16);
         host_i.wr(8'h24, w);
         repeat (2) @(posedge ref_clk);
         {p, m} = split(c1, c2);
         host_i.rd(8'h24, d);
         chk(d, (m & w) | (~m & ~(pin ^ p)));
         chk(poe, ~m);
         chk(pout & m, ~(w ^ p) & m);
         host_i.rd(8'h23, d);
         chk({7'h00, d[7]}, {7'h00, d16 ? w16[7] : ~(i16 ^ a16)});
         chk({6'h00, e16, o16 & d16}, {6'h00, ~d16, d16 & (w16[7] ~^ a16)});
      end
      $display("pin test done");
      summarize;
   end
   // whole run is well under a thousand cycles
   initial begin
      repeat (2000) @(posedge ref_clk);
      n_fail++;
      summarize;
   end
endmodule
